// [verilog/spm_pkg.sv]
// constants, states and carrier types for the serial station session engine
// Contract
// - every frame opens with byte 1Bh
// - length bytes 15-16, low byte first
// - end-of-block 17h; buffered write zeroes 17-18
// - last byte is check code, verified
// - no response to broadcast frames
// - long break aborts, awaits attach
// - buffer timeout flags error, waits break
package spm_pkg;

  // ==========================================================
  // frame bytes
  localparam logic [7:0] SOM          = 8'h1b;
  localparam logic [7:0] CMD_REQ      = 8'h58;
  localparam logic [7:0] CMD_BUF      = 8'h54;
  localparam logic [7:0] EOB          = 8'h17;
  localparam logic [7:0] BCAST_BYTE   = 8'hff;
  localparam logic [7:0] CODE_ATTACH  = 8'h00;
  localparam logic [7:0] CODE_READ    = 8'h01;
  localparam logic [7:0] CODE_WRITE   = 8'h02;
  localparam logic [7:0] SEG_REG_WORD = 8'h08;
  localparam logic [7:0] RESP_FLAG    = 8'h80;
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_NONFATAL = 8'h04;
  localparam logic [7:0] ERR_FATAL    = 8'h0c;

  // ==========================================================
  // zero-based byte positions
  localparam logic [15:0] REQ_LEN      = 16'h0018;
  localparam logic [15:0] POS_CMD      = 16'h0001;
  localparam logic [15:0] POS_ID_LO    = 16'h0002;
  localparam logic [15:0] POS_ID_HI    = 16'h0009;
  localparam logic [15:0] POS_CODE     = 16'h000a;
  localparam logic [15:0] POS_SEG      = 16'h000b;
  localparam logic [15:0] POS_OFS_LO   = 16'h000c;
  localparam logic [15:0] POS_OFS_HI   = 16'h000d;
  localparam logic [15:0] POS_LEN_LO   = 16'h000e;
  localparam logic [15:0] POS_LEN_HI   = 16'h000f;
  localparam logic [15:0] POS_DAT_LO   = 16'h0010;
  localparam logic [15:0] POS_DAT_HI   = 16'h0011;
  localparam logic [15:0] POS_NXT_TYPE = 16'h0013;
  localparam logic [15:0] POS_NXT_LO   = 16'h0014;
  localparam logic [15:0] POS_NXT_HI   = 16'h0015;
  localparam logic [15:0] EOB_FROM_END = 16'h0005;
  localparam logic [15:0] BUF_DATA_POS = 16'h0002;
  localparam logic [15:0] BUF_OVERHEAD = 16'h0008;
  localparam logic [4:0]  RSP_LEN      = 5'h0f;
  localparam logic [4:0]  RSP_POS_CODE = 5'h02;
  localparam logic [4:0]  RSP_POS_MAJ  = 5'h05;
  localparam logic [4:0]  RSP_POS_EOB  = 5'h09;
  localparam logic [4:0]  RSP_POS_BCC  = 5'h0e;

  // ==========================================================
  // states and carriers
  typedef enum logic [2:0] {
    ST_WAIT_BREAK  = 3'b000,
    ST_WAIT_ATTACH = 3'b001,
    ST_WAIT_REQ    = 3'b010,
    ST_WAIT_BUF    = 3'b011,
    ST_SEND        = 3'b100
  } spm_state_e;

  typedef struct packed {
    logic        write;
    logic        bcast;
    logic [7:0]  seg;
    logic [15:0] offset;
    logic [15:0] length;
    logic [15:0] shortData;
  } spm_req_s;

endpackage : spm_pkg

// [verilog/spm_bcc.sv]
// block check code accumulator, kept apart so the algorithm can be swapped
`timescale 1ns/1ns
module spm_bcc (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic       enable,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] code
);

  // ==========================================================
  // rotate and fold; clear wins so a new frame always starts clean
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      code <= 8'h00;
    end else if (clear) begin
      code <= 8'h00;
    end else if (enable) begin
      code <= {code[6:0], code[7]} ^ dataIn;
    end
  end

endmodule : spm_bcc

// [verilog/spm_slave.sv]
// station-side session engine: frame parser, state machine, response builder
`timescale 1ns/1ns
module spm_slave #(
  parameter int TIMER_W = 16
) (
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic               rxValid,
  input  wire logic [7:0]         rxByte,
  input  wire logic               rxBreak,
  input  wire logic [63:0]        stationId,
  input  wire logic [TIMER_W-1:0] bufTimeout,
  input  wire logic               txReady,
  output logic                    txValid,
  output logic      [7:0]         txByte,
  output spm_pkg::spm_req_s       svcReq,
  output logic                    svcCommit,
  output logic                    svcAbort,
  output logic                    svcDataValid,
  output logic      [7:0]         svcData,
  output logic                    protoError,
  output spm_pkg::spm_state_e     linkState
);

  spm_pkg::spm_state_e state;
  spm_pkg::spm_state_e afterSend;
  logic [15:0]        rxIdx;
  logic [15:0]        lastIdx;
  logic [15:0]        bufLen;
  logic [7:0]         cmdByte;
  logic [7:0]         codeByte;
  logic [7:0]         segByte;
  logic [15:0]        ofsWord;
  logic [15:0]        lenWord;
  logic [15:0]        datWord;
  logic [7:0]         nxtType;
  logic [15:0]        nxtLen;
  logic               addrOk;
  logic               bcastOk;
  logic               eobOk;
  logic               curBcast;
  logic [TIMER_W-1:0] bufTimer;
  logic [4:0]         txIdx;
  logic [7:0]         respCode;
  logic [7:0]         respMajor;
  logic [7:0]         rxCode;
  logic [7:0]         txCode;
  logic               rxLive;
  logic               rxStep;
  logic               frameDone;
  logic               wellFormed;
  logic               timeout;
  logic [7:0]         idByte;
  logic [7:0]         respByte;
  logic               txLoad;
  // decision outputs
  logic                evAct;
  spm_pkg::spm_state_e evTarget;
  logic                evSend;
  logic [7:0]          evCode;
  logic [7:0]          evMajor;
  logic                evCommit;
  logic                evAbort;
  logic                evError;
  logic                evLatchReq;

  // ==========================================================
  // receive qualification
  assign rxLive  = (state == spm_pkg::ST_WAIT_ATTACH) || (state == spm_pkg::ST_WAIT_REQ) ||
                   (state == spm_pkg::ST_WAIT_BUF);
  // idle noise before a start byte is skipped rather than counted
  assign rxStep  = rxValid && rxLive && !rxBreak &&
                   ((rxIdx != 16'h0000) || (rxByte == spm_pkg::SOM));
  assign lastIdx = (state == spm_pkg::ST_WAIT_BUF) ? bufLen - 16'h0001
                                                   : spm_pkg::REQ_LEN - 16'h0001;
  assign frameDone = rxStep && (rxIdx == lastIdx);
  assign idByte  = stationId[{rxIdx[2:0] - 3'h2, 3'b000} +: 8];
  assign timeout = (state == spm_pkg::ST_WAIT_BUF) && (bufTimer >= bufTimeout);
  assign wellFormed = (rxByte == rxCode) && eobOk &&
                      ((state == spm_pkg::ST_WAIT_BUF) ? (cmdByte == spm_pkg::CMD_BUF)
                                                       : (cmdByte == spm_pkg::CMD_REQ));
  spm_bcc u_rxBcc (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (frameDone || rxBreak || !rxLive),
    .enable  (rxStep && !frameDone),
    .dataIn  (rxByte),
    .code    (rxCode)
  );

  // ==========================================================
  // field capture
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxIdx    <= 16'h0000;
      cmdByte  <= 8'h00;
      codeByte <= 8'h00;
      segByte  <= 8'h00;
      ofsWord  <= 16'h0000;
      lenWord  <= 16'h0000;
      datWord  <= 16'h0000;
      nxtType  <= 8'h00;
      nxtLen   <= 16'h0000;
      addrOk   <= 1'b0;
      bcastOk  <= 1'b0;
      eobOk    <= 1'b0;
    end else if (rxBreak || frameDone || !rxLive) begin
      rxIdx <= 16'h0000;
    end else if (rxStep) begin
      rxIdx <= rxIdx + 16'h0001;
      if (rxIdx == 16'h0000) begin
        addrOk  <= 1'b1;
        bcastOk <= 1'b1;
        eobOk   <= 1'b0;
        nxtType <= 8'h00;
      end
      if (rxIdx == spm_pkg::POS_CMD) cmdByte <= rxByte;
      if ((rxIdx >= spm_pkg::POS_ID_LO) && (rxIdx <= spm_pkg::POS_ID_HI)) begin
        if (rxByte != idByte) addrOk <= 1'b0;
        if (rxByte != spm_pkg::BCAST_BYTE) bcastOk <= 1'b0;
      end
      if (rxIdx == spm_pkg::POS_CODE) codeByte <= rxByte;
      if (rxIdx == spm_pkg::POS_SEG) segByte <= rxByte;
      if (rxIdx == spm_pkg::POS_OFS_LO) ofsWord[7:0] <= rxByte;
      if (rxIdx == spm_pkg::POS_OFS_HI) ofsWord[15:8] <= rxByte;
      if (rxIdx == spm_pkg::POS_LEN_LO) lenWord[7:0] <= rxByte;
      if (rxIdx == spm_pkg::POS_LEN_HI) lenWord[15:8] <= rxByte;
      if (rxIdx == spm_pkg::POS_DAT_LO) datWord[7:0] <= rxByte;
      if (rxIdx == spm_pkg::POS_DAT_HI) datWord[15:8] <= rxByte;
      if (rxIdx == lastIdx - spm_pkg::EOB_FROM_END) eobOk <= (rxByte == spm_pkg::EOB);
      if (rxIdx == spm_pkg::POS_NXT_TYPE) nxtType <= rxByte;
      if (rxIdx == spm_pkg::POS_NXT_LO) nxtLen[7:0] <= rxByte;
      if (rxIdx == spm_pkg::POS_NXT_HI) nxtLen[15:8] <= rxByte;
    end
  end

  // ==========================================================
  // event decision
  always_comb begin
    evAct      = 1'b0;
    evTarget   = state;
    evSend     = 1'b0;
    evCode     = 8'h00;
    evMajor    = spm_pkg::ERR_NONE;
    evCommit   = 1'b0;
    evAbort    = 1'b0;
    evError    = 1'b0;
    evLatchReq = 1'b0;
    if (rxBreak) begin
      evAct    = 1'b1;
      evTarget = spm_pkg::ST_WAIT_ATTACH;
      evAbort  = (state == spm_pkg::ST_WAIT_BUF);
    end else if (timeout) begin
      evAct    = 1'b1;
      evTarget = spm_pkg::ST_WAIT_BREAK;
      evAbort  = 1'b1;
      evError  = 1'b1;
    end else if (frameDone && !wellFormed) begin
      evAct    = 1'b1;
      evTarget = spm_pkg::ST_WAIT_BREAK;
      evAbort  = (state == spm_pkg::ST_WAIT_BUF);
      evError  = 1'b1;
    end else if (frameDone) begin
      evAct  = 1'b1;
      evCode = codeByte | spm_pkg::RESP_FLAG;
      if (state == spm_pkg::ST_WAIT_ATTACH) begin
        evTarget = (addrOk || bcastOk) ? spm_pkg::ST_WAIT_REQ : spm_pkg::ST_WAIT_BREAK;
        evSend   = addrOk && !bcastOk;
      end else if (state == spm_pkg::ST_WAIT_BUF) begin
        evCode   = spm_pkg::CODE_WRITE | spm_pkg::RESP_FLAG;
        evTarget = spm_pkg::ST_WAIT_REQ;
        evCommit = 1'b1;
        evSend   = !curBcast;
      end else if (!addrOk && !bcastOk) begin
        evAct = 1'b0;
      end else begin
        evSend     = !bcastOk;
        evLatchReq = 1'b1;
        if ((codeByte == spm_pkg::CODE_WRITE) && (nxtType == spm_pkg::CMD_BUF)) begin
          if ((datWord != 16'h0000) || (nxtLen <= spm_pkg::BUF_OVERHEAD)) begin
            evMajor  = spm_pkg::ERR_FATAL;
            evTarget = spm_pkg::ST_WAIT_BREAK;
            evError  = 1'b1;
          end else begin
            evTarget = spm_pkg::ST_WAIT_BUF;
          end
        end else if (codeByte == spm_pkg::CODE_WRITE) begin
          evCommit = 1'b1;
        end else begin
          // reads and unknown codes are refused without dropping the session
          evMajor = spm_pkg::ERR_NONFATAL;
        end
      end
    end
  end

  // ==========================================================
  // state and transmit sequencing
  assign txLoad = (state == spm_pkg::ST_SEND) && (!txValid || txReady) &&
                  (txIdx != spm_pkg::RSP_LEN);
  always_comb begin
    respByte = 8'h00;
    if (txIdx == 5'h00) respByte = spm_pkg::SOM;
    else if (txIdx == 5'h01) respByte = spm_pkg::CMD_REQ;
    else if (txIdx == spm_pkg::RSP_POS_CODE) respByte = respCode;
    else if (txIdx == spm_pkg::RSP_POS_MAJ) respByte = respMajor;
    else if (txIdx == spm_pkg::RSP_POS_EOB) respByte = spm_pkg::EOB;
    else if (txIdx == spm_pkg::RSP_POS_BCC) respByte = txCode;
  end

  spm_bcc u_txBcc (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clear   (state != spm_pkg::ST_SEND),
    .enable  (txLoad && (txIdx != spm_pkg::RSP_POS_BCC)),
    .dataIn  (respByte),
    .code    (txCode)
  );
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= spm_pkg::ST_WAIT_BREAK;
      afterSend <= spm_pkg::ST_WAIT_BREAK;
      txIdx     <= 5'h00;
      txValid   <= 1'b0;
      txByte    <= 8'h00;
      respCode  <= 8'h00;
      respMajor <= 8'h00;
      bufLen    <= 16'h0000;
      curBcast  <= 1'b0;
    end else if (rxBreak) begin
      state   <= spm_pkg::ST_WAIT_ATTACH;
      txValid <= 1'b0;
    end else if (state == spm_pkg::ST_SEND) begin
      if (txLoad) begin
        txByte  <= respByte;
        txValid <= 1'b1;
        txIdx   <= txIdx + 5'h01;
      end else if ((txIdx == spm_pkg::RSP_LEN) && (!txValid || txReady)) begin
        txValid <= 1'b0;
        state   <= afterSend;
      end
    end else if (evAct) begin
      txIdx     <= 5'h00;
      respCode  <= evCode;
      respMajor <= evMajor;
      afterSend <= evTarget;
      state     <= evSend ? spm_pkg::ST_SEND : evTarget;
      if (evLatchReq) begin
        curBcast <= bcastOk;
        bufLen   <= nxtLen;
      end
    end
  end

  // ==========================================================
  // buffer wait timer, cleared whenever the wait is left
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bufTimer <= '0;
    end else if (state != spm_pkg::ST_WAIT_BUF) begin
      bufTimer <= '0;
    end else if (!timeout) begin
      bufTimer <= bufTimer + {{(TIMER_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // service side; payload streams before the check code, so only
  // svcCommit makes it final
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      svcReq       <= '0;
      svcCommit    <= 1'b0;
      svcAbort     <= 1'b0;
      svcDataValid <= 1'b0;
      svcData      <= 8'h00;
      protoError   <= 1'b0;
      linkState    <= spm_pkg::ST_WAIT_BREAK;
    end else begin
      linkState    <= state;
      svcCommit    <= evAct && evCommit && !rxBreak && (state != spm_pkg::ST_SEND);
      svcAbort     <= evAct && evAbort;
      protoError   <= evAct && evError && !rxBreak;
      svcDataValid <= rxStep && (state == spm_pkg::ST_WAIT_BUF) && !frameDone &&
                      (rxIdx >= spm_pkg::BUF_DATA_POS) &&
                      (rxIdx < lastIdx - spm_pkg::EOB_FROM_END);
      svcData      <= rxByte;
      if (evAct && evLatchReq && !rxBreak) begin
        svcReq.write     <= (codeByte == spm_pkg::CODE_WRITE);
        svcReq.bcast     <= bcastOk;
        svcReq.seg       <= segByte;
        svcReq.offset    <= ofsWord;
        svcReq.length    <= lenWord;
        svcReq.shortData <= datWord;
      end
    end
  end

endmodule : spm_slave

// [sim/spm_slave_sva.sv]
// assertion checker for the station session engine, bound to its ports
`timescale 1ns/1ns
module spm_slave_sva (
  input wire logic           ref_clk,
  input wire logic           arst_n,
  input wire logic           rxBreak,
  input wire logic           txReady,
  input wire logic           txValid,
  input wire logic     [7:0] txByte,
  input spm_pkg::spm_req_s   svcReq,
  input wire logic           svcCommit,
  input wire logic           svcAbort,
  input wire logic           svcDataValid,
  input wire logic           protoError,
  input spm_pkg::spm_state_e linkState
);
  // ==========
  // position and running check code of the response byte on offer
  logic [3:0] cnt;
  logic [7:0] bcc;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      bcc <= 8'h00;
    end else if (!txValid) begin
      cnt <= 4'h0;
      bcc <= 8'h00;
    end else if (txReady) begin
      cnt <= cnt + 4'h1;
      bcc <= {bcc[6:0], bcc[7]} ^ txByte;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // assertions
  a_resp_som: assert property (txValid && cnt == 4'h0 |-> txByte == spm_pkg::SOM)
    else $error("response does not open with start byte");
  a_resp_eob: assert property (txValid && cnt == 4'h9 |-> txByte == spm_pkg::EOB)
    else $error("response end-of-block byte misplaced");
  a_resp_bcc: assert property (txValid && cnt == 4'he |-> txByte == bcc)
    else $error("response check code wrong");
  a_resp_len: assert property ($fell(txValid) && !$past(rxBreak) |-> cnt == 4'hf)
    else $error("response length not fifteen bytes");
  a_tx_hold: assert property (txValid && !txReady && !rxBreak |=> txValid && $stable(txByte))
    else $error("offered byte changed before taken");
  a_bcast_silent: assert property (svcCommit && svcReq.bcast |=> !txValid [*8])
    else $error("answer sent to broadcast");
  a_commit_resp: assert property (svcCommit && !svcReq.bcast |-> ##[1:2] txValid)
    else $error("directed write got no response");
  a_break_attach: assert property (rxBreak |-> ##2 linkState == spm_pkg::ST_WAIT_ATTACH)
    else $error("break did not lead to attach wait");
  a_abort_state: assert property (svcAbort |-> linkState == spm_pkg::ST_WAIT_BUF ##1
    linkState inside {spm_pkg::ST_WAIT_ATTACH, spm_pkg::ST_WAIT_BREAK})
    else $error("abort outside buffer wait");
  a_data_buf: assert property (svcDataValid |-> linkState == spm_pkg::ST_WAIT_BUF)
    else $error("payload byte outside buffer wait");
  a_break_quiet: assert property (linkState == spm_pkg::ST_WAIT_BREAK |->
    !txValid && !svcCommit)
    else $error("activity while waiting for break");
  c_bcast: cover property (svcCommit && svcReq.bcast);
  c_abort: cover property (svcAbort);
  c_error: cover property (protoError);
endmodule : spm_slave_sva

bind spm_slave spm_slave_sva u_sva (
  .ref_clk(ref_clk), .arst_n(arst_n), .rxBreak(rxBreak), .txReady(txReady),
  .txValid(txValid), .txByte(txByte), .svcReq(svcReq), .svcCommit(svcCommit),
  .svcAbort(svcAbort), .svcDataValid(svcDataValid), .protoError(protoError),
  .linkState(linkState));

// [sim/spm_master_model.sv]
// master-side model: sends bytes and breaks, paces the transmitter, waits for replies
`timescale 1ns/1ns
module spm_master_model #(
  parameter int BDELAY = 12
) (
  input  wire logic       ref_clk,
  input  wire logic       txValid,
  output logic            txReady,
  output logic            rxValid,
  output logic      [7:0] rxByte,
  output logic            rxBreak
);
  int taken;
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    rxBreak = 1'b0;
    txReady = 1'b0;
  end
  // random stalls so that held bytes are exercised
  always @(negedge ref_clk) txReady <= ($urandom_range(3) != 0);
  always @(posedge ref_clk) if (txValid && txReady) taken <= taken + 1;
  task automatic sendFrame(input logic [7:0] fr[$]);
    foreach (fr[i]) begin
      @(negedge ref_clk);
      rxValid = 1'b1;
      rxByte = fr[i];
      @(negedge ref_clk);
      rxValid = 1'b0;
      rxByte = ~fr[i]; // idle line never shows a stale byte
    end
  endtask : sendFrame
  // abort of all master processing ends in a fresh session
  task automatic sendBreak;
    @(negedge ref_clk);
    rxBreak = 1'b1;
    @(negedge ref_clk);
    rxBreak = 1'b0;
  endtask : sendBreak
  task automatic awaitReply(input int n);
    int start;
    int k;
    start = taken;
    k = 0;
    if (n == 0) repeat (BDELAY) @(negedge ref_clk);
    else while (taken < start + n && k < 1000) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (4) @(negedge ref_clk);
  endtask : awaitReply
endmodule : spm_master_model

// [sim/serial_plc_master_session_tb.sv]
// self-checking bench for the station session engine
`timescale 1ns/1ns
module serial_plc_master_session_tb;
  logic                ref_clk;
  logic                arst_n;
  logic                rxValid;
  logic [7:0]          rxByte;
  logic                rxBreak;
  logic [63:0]         stationId;
  logic [15:0]         bufTimeout;
  logic                txReady;
  logic                txValid;
  logic [7:0]          txByte;
  spm_pkg::spm_req_s   svcReq;
  logic                svcCommit;
  logic                svcAbort;
  logic                svcDataValid;
  logic [7:0]          svcData;
  logic                protoError;
  spm_pkg::spm_state_e linkState;
  logic [61:0]         exq[$];
  logic [7:0]          fr[$];
  logic [63:0]         id;
  int                  n_errors = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  localparam logic [63:0] BCAST = {8{spm_pkg::BCAST_BYTE}};
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  spm_slave #(.TIMER_W(16)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .rxValid(rxValid), .rxByte(rxByte),
    .rxBreak(rxBreak), .stationId(stationId), .bufTimeout(bufTimeout), .txReady(txReady),
    .txValid(txValid), .txByte(txByte), .svcReq(svcReq), .svcCommit(svcCommit),
    .svcAbort(svcAbort), .svcDataValid(svcDataValid), .svcData(svcData),
    .protoError(protoError), .linkState(linkState));
  spm_master_model m (
    .ref_clk(ref_clk), .txValid(txValid), .txReady(txReady), .rxValid(rxValid),
    .rxByte(rxByte), .rxBreak(rxBreak));
  // ==========
  // checking
  task automatic chk(input string what, input logic [61:0] exp, input logic [61:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic note(input logic [3:0] k, input logic [57:0] v);
    if (exq.size() == 0) chk("unexpected event", 62'h0, {k, v});
    else chk("event", exq.pop_front(), {k, v});
  endtask : note
  always @(posedge ref_clk) begin
    if (arst_n) begin
      if (txValid && txReady) note(4'h1, {50'h0, txByte});
      if (svcDataValid) note(4'h2, {50'h0, svcData});
      if (svcCommit) note(4'h3, svcReq);
      if (svcAbort) note(4'h4, 58'h0);
      if (protoError) note(4'h5, 58'h0);
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // ==========
  // frames and expectations
  function automatic logic [7:0] bccOf(input logic [7:0] q[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) c = {c[6:0], c[7]} ^ q[i];
    return c;
  endfunction : bccOf
  task automatic ex(input logic [3:0] k, input logic [57:0] v);
    exq.push_back({k, v});
  endtask : ex
  task automatic expResp(input logic [7:0] code, input logic [7:0] major);
    logic [7:0] r[$];
    r = '{spm_pkg::SOM, spm_pkg::CMD_REQ, code, 8'h00, 8'h00, major, 8'h00, 8'h00, 8'h00,
          spm_pkg::EOB, 8'h00, 8'h00, 8'h00, 8'h00};
    r.push_back(bccOf(r));
    foreach (r[i]) ex(4'h1, {50'h0, r[i]});
  endtask : expResp
  task automatic mkReq(input logic [63:0] sid, input logic [7:0] code, input logic [15:0] ofs,
                       input logic [15:0] len, input logic [15:0] dat, input logic [15:0] nl);
    fr = '{spm_pkg::SOM, spm_pkg::CMD_REQ};
    for (int i = 0; i < 8; i++) fr.push_back(sid[8*i +: 8]);
    fr = {fr, code, spm_pkg::SEG_REG_WORD, ofs[7:0], ofs[15:8], len[7:0], len[15:8]};
    fr = {fr, dat[7:0], dat[15:8], spm_pkg::EOB, (nl != 0) ? spm_pkg::CMD_BUF : 8'h00};
    fr = {fr, nl[7:0], nl[15:8], 8'h00};
    fr.push_back(bccOf(fr));
  endtask : mkReq
  task automatic xfer(input int n);
    m.sendFrame(fr);
    m.awaitReply(n);
  endtask : xfer
  task automatic wr(input logic bc, input int w);
    logic [15:0] ofs;
    logic [15:0] dat;
    logic [15:0] len;
    ofs = 16'($urandom);
    dat = (w == 0) ? 16'($urandom) : 16'h0000;
    len = (w == 0) ? 16'h0001 : 16'(w);
    mkReq(bc ? BCAST : id, spm_pkg::CODE_WRITE, ofs, len, dat, (w == 0) ? 16'h0 : 16'(2*w + 8));
    if (w != 0) begin
      if (!bc) expResp(8'h82, spm_pkg::ERR_NONE);
      xfer(bc ? 0 : 15);
      fr = '{spm_pkg::SOM, spm_pkg::CMD_BUF};
      repeat (2 * w) begin
        fr.push_back(8'($urandom));
        ex(4'h2, {50'h0, fr[$]});
      end
      fr = {fr, spm_pkg::EOB, 8'h00, 8'h00, 8'h00, 8'h00};
      fr.push_back(bccOf(fr));
    end
    ex(4'h3, {1'b1, bc, spm_pkg::SEG_REG_WORD, ofs, len, dat});
    if (!bc) expResp(8'h82, spm_pkg::ERR_NONE);
    xfer(bc ? 0 : 15);
  endtask : wr
  task automatic doAttach;
    m.sendBreak();
    mkReq(id, spm_pkg::CODE_ATTACH, 16'h0, 16'h0, 16'h0, 16'h0);
    expResp(8'h80, spm_pkg::ERR_NONE);
    xfer(15);
    chk("linkState", 62'(spm_pkg::ST_WAIT_REQ), 62'(linkState));
  endtask : doAttach
  task automatic bufReq(input logic [15:0] dat, input logic [7:0] major);
    mkReq(id, spm_pkg::CODE_WRITE, 16'h0, 16'h1, dat, 16'h000a);
    if (dat != 0) ex(4'h5, 58'h0);
    expResp(8'h82, major);
  endtask : bufReq
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // ==========
  // main sequence
  initial begin
    arst_n = 1'b0;
    bufTimeout = 16'd3000;
    void'($urandom(32'h070747bb));
    id = {$urandom, $urandom};
    stationId = id;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    mkReq(id, spm_pkg::CODE_WRITE, 16'h0, 16'h1, 16'h0, 16'h0);
    xfer(0);
    doAttach();
    $display("test attach finished");
    for (int i = 0; i < 3; i++) wr(1'b0, 0);
    mkReq(~id, spm_pkg::CODE_WRITE, 16'h0, 16'h1, 16'h0, 16'h0);
    xfer(0);
    mkReq(id, spm_pkg::CODE_READ, 16'h0063, 16'h000a, 16'h0, 16'h0);
    expResp(8'h81, spm_pkg::ERR_NONFATAL);
    xfer(15);
    $display("test short write finished");
    wr(1'b0, 10);
    wr(1'b0, 1);
    wr(1'b1, 0);
    wr(1'b1, 3);
    m.sendBreak();
    mkReq(BCAST, spm_pkg::CODE_ATTACH, 16'h0, 16'h0, 16'h0, 16'h0);
    xfer(0);
    chk("linkState", 62'(spm_pkg::ST_WAIT_REQ), 62'(linkState));
    $display("test buffered and broadcast finished");
    mkReq(id, spm_pkg::CODE_WRITE, 16'h0, 16'h1, 16'h0, 16'h0);
    fr[23] = ~fr[23];
    ex(4'h5, 58'h0);
    xfer(0);
    chk("linkState", 62'(spm_pkg::ST_WAIT_BREAK), 62'(linkState));
    doAttach();
    bufReq(16'h1234, spm_pkg::ERR_FATAL);
    xfer(15);
    chk("linkState", 62'(spm_pkg::ST_WAIT_BREAK), 62'(linkState));
    doAttach();
    $display("test malformed finished");
    bufTimeout = 16'd40;
    bufReq(16'h0, spm_pkg::ERR_NONE);
    ex(4'h4, 58'h0);
    ex(4'h5, 58'h0);
    xfer(15);
    repeat (60) @(negedge ref_clk);
    chk("linkState", 62'(spm_pkg::ST_WAIT_BREAK), 62'(linkState));
    bufTimeout = 16'd3000;
    doAttach();
    bufReq(16'h0, spm_pkg::ERR_NONE);
    ex(4'h4, 58'h0);
    xfer(15);
    doAttach();
    $display("test abort finished");
    chk("pending events", 62'h0, 62'(exq.size()));
    conclude();
  end
endmodule : serial_plc_master_session_tb
